// >>> rtl/rpb_top.sv
/*
  Retransmit priority buffer: transmit store that holds packets until they
  are acknowledged, re-arbitrates them after a rewind and bumps retried
  responses; receive store with priority based admission.
  Assumes one packet per beat and a PHY that works on ref_clk.
//
// Function
// R1: Transmit and receive stores each hold 8, 16 or 32 packets, set at build.
// R2: Every sent packet stays stored until acknowledged, resent when refused.
// R3: PHY gives next ackID; each packet handed over is tagged with it.
// R4: PHY updates last acked pointer; stored copies up to it are freed.
// R5: On refusal PHY aborts, rewinds and raises rewind strobe with pointer update.
// R6: Rewind strobe spans the packet in progress, else at least two cycles.
// R7: After rewind release, free acknowledged packets first, then resume sending.
// R8: Send responses, then priority 2-3, 1, 0 requests, each in arrival order.
// R9: On retry every sent unaccepted packet returns to the queue for arbitration.
// R10: Resend from the retried ackID onward, order by new arbitration.
// R11: A retried response is resent with its priority raised by one.
// R12: Only the retried response is bumped, again per retry, capped at 3.
// R13: Acks come in order; a later retry implies earlier ones accepted.
// R14: Partner accepts error free packets with room, otherwise retry or error.
// R15: Both flow control styles, with a smaller receiver controlled only build.
// R16: Receiver controlled throttling happens only through PHY retries.
// R17: Receive accepts all with 4 free, 1-3 with 3, 2-3 with 2.
// R18: One free slot takes priority 3 responses only; none free takes nothing.
// R19: Packets may cross between independent clocks on the two sides.
// R20: AckID comparisons use modulo arithmetic over the identifier width.
*/
`timescale 1ns/10ps
module rpb_top import rpb_pkg::*; #(
  parameter int TX_DEPTH = DEF_TX_DEPTH,
  parameter int RX_DEPTH = DEF_RX_DEPTH,
  parameter int PKT_W    = DEF_PKT_W,
  parameter int ACK_W    = DEF_ACK_W,
  parameter bit RX_ONLY  = 1'b0
)(
  input  wire  logic             ref_clk,
  input  wire  logic             sys_rst,
  input  wire  logic             tx_fc_en,
  input  wire  logic [ACK_W-1:0] partner_buf_stat,
  input  wire  logic             s_valid,
  output logic                   s_ready,
  input  wire  logic [PKT_W-1:0] s_data,
  input  wire  logic [1:0]       s_prio,
  input  wire  logic             s_resp,
  output logic                   phy_valid,
  input  wire  logic             phy_ready,
  output logic [PKT_W-1:0]       phy_data,
  output logic [1:0]             phy_prio,
  output logic                   phy_resp,
  output logic [ACK_W-1:0]       phy_ackid,
  input  wire  logic [ACK_W-1:0] next_ackid_ptr,
  input  wire  logic [ACK_W-1:0] last_acked_ptr,
  input  wire  logic             rewind_strobe,
  input  wire  logic             rx_in_valid,
  output logic                   rx_in_accept,
  input  wire  logic [PKT_W-1:0] rx_in_data,
  input  wire  logic [1:0]       rx_in_prio,
  input  wire  logic             rx_in_resp,
  output logic                   m_valid,
  input  wire  logic             m_ready,
  output logic [PKT_W-1:0]       m_data,
  output logic [1:0]             m_prio,
  output logic                   m_resp
);

  localparam int TI_W = $clog2(TX_DEPTH);
  localparam int RI_W = $clog2(RX_DEPTH);
  localparam int RC_W = RI_W + 1;

  // ----------------------------------------------------------------------
  // Build checks
  // ----------------------------------------------------------------------
  // Store depths are limited to the three supported sizes
  if (!(TX_DEPTH inside {8, 16, 32}) || !(RX_DEPTH inside {8, 16, 32})) begin : g_bad_depth
    $error("store depth must be 8, 16 or 32");                     // R1
  end
  if (ACK_W < 3 || PKT_W < 1) begin : g_bad_width
    $error("ackID or packet width too small");
  end

  // ----------------------------------------------------------------------
  // Transmit store state
  // ----------------------------------------------------------------------
  rpb_slot_t          slot_st   [TX_DEPTH];
  rpb_slot_t          next_slot_st   [TX_DEPTH];
  logic [1:0]         slot_prio [TX_DEPTH];
  logic [1:0]         next_slot_prio [TX_DEPTH];
  logic               slot_resp [TX_DEPTH];
  logic               next_slot_resp [TX_DEPTH];
  logic [SEQ_W-1:0]   slot_seq  [TX_DEPTH];
  logic [SEQ_W-1:0]   next_slot_seq  [TX_DEPTH];
  logic [ACK_W-1:0]   slot_ack  [TX_DEPTH];
  logic [ACK_W-1:0]   next_slot_ack  [TX_DEPTH];
  logic [PKT_W-1:0]   slot_data [TX_DEPTH];
  logic [PKT_W-1:0]   next_slot_data [TX_DEPTH];
  logic [SEQ_W-1:0]   seq_cnt;
  logic [SEQ_W-1:0]   next_seq_cnt;
  logic               rew_q;
  logic               rew_rel;
  logic               free_found;
  logic [TI_W-1:0]    free_idx;
  logic               arb_found;
  logic [TI_W-1:0]    arb_idx;
  logic [1:0]         arb_cls;
  logic [SEQ_W-1:0]   arb_seq;
  logic               fc_ok;
  logic [ACK_W-1:0]   outstanding;
  logic [ACK_W-1:0]   retry_id;
  logic               any_sent;
  logic               any_drop;

  // Rewind takes effect on its falling edge, after the pointers settled
  assign rew_rel     = rew_q && !rewind_strobe;                    // R7
  assign retry_id    = last_acked_ptr + ACK_W'(1);                 // R13
  assign outstanding = next_ackid_ptr - last_acked_ptr - ACK_W'(1); // R20

  // Transmitter flow control is compiled out in the lean build
  assign fc_ok = RX_ONLY ? 1'b1 : (!tx_fc_en || (outstanding < partner_buf_stat)); // R15 R16

  // Acked when the tag is at or behind last acked, modulo the ID width
  function automatic logic ack_done(input logic [ACK_W-1:0] tag, input logic [ACK_W-1:0] last);
    logic [ACK_W-1:0] d;
    d = last - tag;
    return !d[ACK_W-1];                                            // R20
  endfunction

  // Free slot search and priority arbitration over queued slots
  always_comb begin
    free_found = 1'b0;
    free_idx   = '0;
    arb_found  = 1'b0;
    arb_idx    = '0;
    arb_cls    = CLS_REQ_P0;
    arb_seq    = '0;
    any_sent   = 1'b0;
    for (int i = 0; i < TX_DEPTH; i++) begin
      if (slot_st[i] == SLOT_FREE && !free_found) begin
        free_found = 1'b1;
        free_idx   = TI_W'(i);
      end
      if (slot_st[i] == SLOT_SENT)
        any_sent = 1'b1;
      if (slot_st[i] == SLOT_QUEUED &&
          (!arb_found || rpb_class(slot_resp[i], slot_prio[i]) < arb_cls ||
           (rpb_class(slot_resp[i], slot_prio[i]) == arb_cls && rpb_older(slot_seq[i], arb_seq)))) begin
        arb_found = 1'b1;                                          // R8
        arb_idx   = TI_W'(i);
        arb_cls   = rpb_class(slot_resp[i], slot_prio[i]);
        arb_seq   = slot_seq[i];
      end
    end
  end

  // Plain handshakes on both sides; a clock crossing stage may sit outside
  assign s_ready = free_found;                                     // R19

  // ----------------------------------------------------------------------
  // Presentation register toward the PHY
  // ----------------------------------------------------------------------
  logic               pres_valid;
  logic               next_pres_valid;
  logic [TI_W-1:0]    pres_idx;
  logic [TI_W-1:0]    next_pres_idx;
  logic [PKT_W-1:0]   next_phy_data;
  logic [1:0]         next_phy_prio;
  logic               next_phy_resp;
  logic               phy_take;

  assign phy_valid = pres_valid && !rewind_strobe;                 // R7
  assign phy_take  = phy_valid && phy_ready;
  assign phy_ackid = next_ackid_ptr;                               // R3

  // One packet staged at a time; a rewind drops it back into the queue
  always_comb begin
    next_pres_valid = pres_valid;
    next_pres_idx   = pres_idx;
    next_phy_data   = phy_data;
    next_phy_prio   = phy_prio;
    next_phy_resp   = phy_resp;
    if (rewind_strobe || phy_take) begin
      next_pres_valid = 1'b0;                                      // R5 R6
    end else if (!pres_valid && !rew_q && fc_ok && arb_found) begin
      next_pres_valid = 1'b1;                                      // R8 R10
      next_pres_idx   = arb_idx;
      next_phy_data   = slot_data[arb_idx];
      next_phy_prio   = slot_prio[arb_idx];
      next_phy_resp   = slot_resp[arb_idx];
    end
  end

  // ----------------------------------------------------------------------
  // Slot updates: fill, tag, free and requeue
  // ----------------------------------------------------------------------
  always_comb begin
    next_seq_cnt = seq_cnt;
    any_drop     = 1'b0;
    for (int i = 0; i < TX_DEPTH; i++) begin
      next_slot_st[i]   = slot_st[i];
      next_slot_prio[i] = slot_prio[i];
      next_slot_resp[i] = slot_resp[i];
      next_slot_seq[i]  = slot_seq[i];
      next_slot_ack[i]  = slot_ack[i];
      next_slot_data[i] = slot_data[i];
      // Hold while a rewind is open; the old pointers are not yet valid
      if (slot_st[i] == SLOT_SENT && !rewind_strobe) begin
        if (ack_done(slot_ack[i], last_acked_ptr)) begin
          next_slot_st[i] = SLOT_FREE;                             // R2 R4 R7
          any_drop        = 1'b1;
        end else if (rew_rel) begin
          next_slot_st[i] = SLOT_QUEUED;                           // R9 R10
          if (slot_resp[i] && slot_ack[i] == retry_id && slot_prio[i] != PRIO_MAX)
            next_slot_prio[i] = slot_prio[i] + 2'h1;               // R11 R12
        end
      end
    end
    if (s_valid && free_found) begin
      next_slot_st[free_idx]   = SLOT_QUEUED;
      next_slot_prio[free_idx] = s_prio;
      next_slot_resp[free_idx] = s_resp;
      next_slot_seq[free_idx]  = seq_cnt;
      next_slot_data[free_idx] = s_data;
      next_seq_cnt             = seq_cnt + SEQ_W'(1);
    end
    if (phy_take) begin
      next_slot_st[pres_idx]  = SLOT_SENT;                         // R2
      next_slot_ack[pres_idx] = next_ackid_ptr;                    // R3
    end
  end

  // Registers of the transmit side
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < TX_DEPTH; i++) begin
        slot_st[i]   <= SLOT_FREE;
        slot_prio[i] <= '0;
        slot_resp[i] <= 1'b0;
        slot_seq[i]  <= '0;
        slot_ack[i]  <= '0;
        slot_data[i] <= '0;
      end
      seq_cnt    <= '0;
      rew_q      <= 1'b0;
      pres_valid <= 1'b0;
      pres_idx   <= '0;
      phy_data   <= '0;
      phy_prio   <= '0;
      phy_resp   <= 1'b0;
    end else begin
      slot_st    <= next_slot_st;
      slot_prio  <= next_slot_prio;
      slot_resp  <= next_slot_resp;
      slot_seq   <= next_slot_seq;
      slot_ack   <= next_slot_ack;
      slot_data  <= next_slot_data;
      seq_cnt    <= next_seq_cnt;
      rew_q      <= rewind_strobe;
      pres_valid <= next_pres_valid;
      pres_idx   <= next_pres_idx;
      phy_data   <= next_phy_data;
      phy_prio   <= next_phy_prio;
      phy_resp   <= next_phy_resp;
    end
  end

  // ----------------------------------------------------------------------
  // Receive store
  // ----------------------------------------------------------------------
  logic [PKT_W+2:0]   rx_mem [RX_DEPTH];
  logic [PKT_W+2:0]   next_rx_mem [RX_DEPTH];
  logic [RI_W-1:0]    rx_wr;
  logic [RI_W-1:0]    next_rx_wr;
  logic [RI_W-1:0]    rx_rd;
  logic [RI_W-1:0]    next_rx_rd;
  logic [RC_W-1:0]    rx_cnt;
  logic [RC_W-1:0]    next_rx_cnt;
  logic               rx_push;
  logic               rx_pop;

  rpb_adm_if #(.CNT_W(RC_W)) adm_bus ();

  assign adm_bus.free_slots = RC_W'(RX_DEPTH) - rx_cnt;
  assign adm_bus.prio       = rx_in_prio;
  assign adm_bus.resp       = rx_in_resp;
  assign rx_in_accept       = adm_bus.accept;                      // R16 R18
  assign rx_push            = rx_in_valid && adm_bus.accept;
  assign rx_pop             = m_valid && m_ready;
  assign m_valid            = (rx_cnt != '0);
  assign {m_resp, m_prio, m_data} = rx_mem[rx_rd];

  rpb_rx_admit #(.CNT_W(RC_W)) u_admit (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .adm     (adm_bus)
  );

  // Plain first-in first-out order on the receive side
  always_comb begin
    next_rx_mem = rx_mem;
    next_rx_wr  = rx_wr;
    next_rx_rd  = rx_rd;
    next_rx_cnt = rx_cnt;
    if (rx_push) begin
      next_rx_mem[rx_wr] = {rx_in_resp, rx_in_prio, rx_in_data};
      next_rx_wr         = rx_wr + RI_W'(1);
    end
    if (rx_pop)
      next_rx_rd = rx_rd + RI_W'(1);
    if (rx_push && !rx_pop)
      next_rx_cnt = rx_cnt + RC_W'(1);
    else if (rx_pop && !rx_push)
      next_rx_cnt = rx_cnt - RC_W'(1);
  end

  // Registers of the receive side
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < RX_DEPTH; i++)
        rx_mem[i] <= '0;
      rx_wr  <= '0;
      rx_rd  <= '0;
      rx_cnt <= '0;
    end else begin
      rx_mem <= next_rx_mem;
      rx_wr  <= next_rx_wr;
      rx_rd  <= next_rx_rd;
      rx_cnt <= next_rx_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_tag_ackid: assert property (phy_take |=> slot_ack[$past(pres_idx)] == $past(next_ackid_ptr)) // R3
    else $error("sent packet not tagged with the offered ackID");
  a_hold_in_rewind: assert property ((rewind_strobe || rew_q) |-> !phy_valid) // R7
    else $error("packet offered during or at release of a rewind");
  a_keep_unacked: assert property ((phy_take && !rewind_strobe) |=> slot_st[$past(pres_idx)] == SLOT_SENT) // R2
    else $error("sent packet not kept for retransmission");
  a_requeue_all: assert property ((rew_rel && !any_drop) |=> !any_sent) // R9
    else $error("unaccepted packet left out of requeue");
  a_bump_retried: assert property ((rew_rel && slot_st[0] == SLOT_SENT && slot_resp[0] && // R11
      slot_ack[0] == retry_id && slot_prio[0] != PRIO_MAX) |=> slot_prio[0] == $past(slot_prio[0]) + 2'h1)
    else $error("retried response not bumped");
  a_no_bump_other: assert property ((rew_rel && slot_st[0] == SLOT_SENT && slot_ack[0] != retry_id) |=> // R12
      $stable(slot_prio[0]))
    else $error("priority changed on a packet that was not retried");
  a_arb_order: assert property ((!pres_valid && !rewind_strobe && !rew_q && fc_ok && arb_found) |=> // R8
      (rpb_class(phy_resp, phy_prio) == $past(arb_cls)) && pres_valid)
    else $error("staged packet is not the best queued class");
  a_rx_bound: assert property (rx_cnt == RC_W'(RX_DEPTH) |-> !rx_in_accept) // R1 R18
    else $error("receive store overrun");

  c_rewind_busy: cover property (pres_valid ##1 rewind_strobe [*2] ##1 !rewind_strobe);
  c_bump: cover property (rew_rel && any_sent ##1 phy_take && phy_resp && phy_prio == PRIO_MAX);
  c_tx_full: cover property (!s_ready && s_valid);

endmodule // rpb_top

// >>> rtl/rpb_pkg.sv
/*
  Shared constants, types and decode helpers of the retransmit priority buffer.
  Assumes a single ref_clk domain and packets carried as one wide word each.
*/
package rpb_pkg;

  // ----------------------------------------------------------------------
  // Build defaults
  // ----------------------------------------------------------------------
  localparam int DEF_TX_DEPTH = 8;
  localparam int DEF_RX_DEPTH = 8;
  localparam int DEF_PKT_W    = 64;
  localparam int DEF_ACK_W    = 6;       // Width of an ackID, value is a plain default
  localparam int SEQ_W        = 8;       // Arrival stamp, compared modulo its width
  localparam int PRIO_W       = 2;

  // ----------------------------------------------------------------------
  // Priorities, classes and receive thresholds
  // ----------------------------------------------------------------------
  localparam logic [1:0] PRIO_MAX     = 2'h3;
  localparam logic [1:0] CLS_RESP     = 2'h0;
  localparam logic [1:0] CLS_REQ_HI   = 2'h1;
  localparam logic [1:0] CLS_REQ_P1   = 2'h2;
  localparam logic [1:0] CLS_REQ_P0   = 2'h3;
  localparam int         RX_FREE_ALL  = 4;
  localparam int         RX_FREE_P1   = 3;
  localparam int         RX_FREE_P2   = 2;
  localparam int         RX_FREE_P3R  = 1;
  localparam int         MIN_REWIND_CYC = 2;   // Shortest rewind outside a packet

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SLOT_FREE, SLOT_QUEUED, SLOT_SENT} rpb_slot_t;

  // Transmit arbitration class, lower is served first
  function automatic logic [1:0] rpb_class(input logic resp, input logic [1:0] prio);
    if (resp)
      return CLS_RESP;
    else if (prio[1])
      return CLS_REQ_HI;
    else if (prio[0])
      return CLS_REQ_P1;
    else
      return CLS_REQ_P0;
  endfunction

  // Modulo age test: a was stamped before b
  function automatic logic rpb_older(input logic [SEQ_W-1:0] a, input logic [SEQ_W-1:0] b);
    logic [SEQ_W-1:0] d;
    d = a - b;
    return d[SEQ_W-1];
  endfunction

endpackage

// >>> rtl/rpb_adm_if.sv
/*
  Carrier between the buffer core and the receive admission check.
  Assumes both ends sit in the same ref_clk domain.
*/
`timescale 1ns/10ps
interface rpb_adm_if #(parameter int CNT_W = 4);
  logic [CNT_W-1:0] free_slots;
  logic [1:0]       prio;
  logic             resp;
  logic             accept;
  modport core (output free_slots, output prio, output resp, input accept);
  modport adm  (input free_slots, input prio, input resp, output accept);
endinterface

// >>> rtl/rpb_rx_admit.sv
/*
  Receive admission: decides from free space and packet priority whether an
  incoming packet may enter the receive store. Assumes the core offers it
  the free slot count of the current cycle.
*/
`timescale 1ns/10ps
module rpb_rx_admit import rpb_pkg::*; #(
  parameter int CNT_W = 4
)(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  rpb_adm_if.adm    adm
);

  // ----------------------------------------------------------------------
  // Priority allowance against remaining space
  // ----------------------------------------------------------------------
  // One slot is held back per priority step so high priority never starves
  always_comb begin
    if (adm.free_slots >= CNT_W'(RX_FREE_ALL))
      adm.accept = 1'b1;                                          // R17
    else if (adm.free_slots == CNT_W'(RX_FREE_P1))
      adm.accept = (adm.prio != 2'h0);                            // R17
    else if (adm.free_slots == CNT_W'(RX_FREE_P2))
      adm.accept = adm.prio[1];                                   // R17
    else if (adm.free_slots == CNT_W'(RX_FREE_P3R))
      adm.accept = adm.resp && (adm.prio == PRIO_MAX);            // R18
    else
      adm.accept = 1'b0;                                          // R18
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_rx_roomy: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
    (adm.free_slots >= CNT_W'(RX_FREE_ALL)) |-> adm.accept)
    else $error("packet refused with ample receive space");
  a_rx_two_free: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
    (adm.free_slots == CNT_W'(RX_FREE_P2)) |-> (adm.accept == adm.prio[1]))
    else $error("wrong allowance with two free slots");
  a_rx_last_slot: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
    (adm.free_slots <= CNT_W'(RX_FREE_P3R) && adm.accept) |-> (adm.resp && adm.prio == PRIO_MAX && adm.free_slots != '0))
    else $error("last receive slot given to a non top response");
  c_rx_refuse: cover property (@(posedge ref_clk) disable iff (sys_rst) !adm.accept);

endmodule // rpb_rx_admit

// >>> tb/rpb_phy_model.sv
/*
  PHY model for the buffer: takes packets, logs them, hands out ackIDs,
  acknowledges and rewinds when told. Assumes a buffer top on ref_clk.
*/
`timescale 1ns/10ps
module rpb_phy_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        phy_valid,
  output logic             phy_ready,
  input  wire logic [63:0] phy_data,
  input  wire logic [1:0]  phy_prio,
  input  wire logic        phy_resp,
  input  wire logic [5:0]  phy_ackid,
  output logic [5:0]       next_ackid_ptr,
  output logic [5:0]       last_acked_ptr,
  output logic             rewind_strobe
);
  // ----------------------------------------------------------------------
  // Take log, entry is {ackid, resp, prio, data}
  // ----------------------------------------------------------------------
  logic [72:0] pkt_log [0:63];
  int          n_got;
  logic        slow = 1'b0;
  logic [5:0]  rew_id = 6'h00;  // Rewound ackID, loaded while the strobe is up
  initial last_acked_ptr = 6'h3f;
  initial rewind_strobe = 1'b0;

  // Slow mode idles every other cycle to stretch the handshake
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      n_got <= 0;
      next_ackid_ptr <= 6'h00;
      phy_ready <= 1'b0;
    end else begin
      phy_ready <= slow ? ~phy_ready : 1'b1;
      if (rewind_strobe)
        next_ackid_ptr <= rew_id;
      else if (phy_valid && phy_ready) begin
        pkt_log[n_got] <= {phy_ackid, phy_resp, phy_prio, phy_data};
        n_got <= n_got + 1;
        next_ackid_ptr <= next_ackid_ptr + 6'h01;
      end
    end
  end

  // Acceptance moves the last acked pointer only
  task automatic ack(input logic [5:0] id);
    last_acked_ptr = id;
  endtask

  // Refusal: both pointers rewound under a two cycle strobe, no packet open
  task automatic rewind(input logic [5:0] id);
    rew_id = id;
    rewind_strobe = 1'b1;
    last_acked_ptr = id - 6'h01;
    repeat (2) @(posedge ref_clk);
    #1 rewind_strobe = 1'b0;
  endtask
endmodule // rpb_phy_model

// >>> tb/tb_retransmit_priority_buffer.sv
/*
  Self-checking bench of the buffer top with a PHY model on the transmit side
  and the bench standing in for the PHY on receive. Assumes one ref_clk.
*/
`timescale 1ns/10ps
module tb_retransmit_priority_buffer;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic ref_clk = 1'b0, sys_rst = 1'b1, tx_fc_en = 1'b1, s_valid = 1'b0, s_ready, s_resp = 1'b0;
  logic phy_valid, phy_ready, phy_resp, rewind_strobe, rx_in_valid = 1'b0, rx_in_accept, rx_in_resp = 1'b0;
  logic m_valid, m_ready = 1'b0, m_resp;
  logic [1:0] s_prio = 2'h0, phy_prio, rx_in_prio = 2'h0, m_prio;
  logic [5:0] partner_buf_stat = 6'h3f, phy_ackid, next_ackid_ptr, last_acked_ptr;
  logic [63:0] s_data = '0, phy_data, rx_in_data = '0, m_data;
  int n_fail = 0, cmp_count = 0;

  rpb_top dut (.ref_clk, .sys_rst, .tx_fc_en, .partner_buf_stat, .s_valid, .s_ready, .s_data, .s_prio,
    .s_resp, .phy_valid, .phy_ready, .phy_data, .phy_prio, .phy_resp, .phy_ackid, .next_ackid_ptr,
    .last_acked_ptr, .rewind_strobe, .rx_in_valid, .rx_in_accept, .rx_in_data, .rx_in_prio, .rx_in_resp,
    .m_valid, .m_ready, .m_data, .m_prio, .m_resp);
  rpb_phy_model phy (.ref_clk, .sys_rst, .phy_valid, .phy_ready, .phy_data, .phy_prio, .phy_resp,
    .phy_ackid, .next_ackid_ptr, .last_acked_ptr, .rewind_strobe);

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [72:0] got, input logic [72:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  // Valid stays up after the take so back to back pushes never glitch it
  task automatic push(input logic [63:0] d, input logic [1:0] p, input logic r);
    int k;
    s_valid = 1'b1;
    s_data = d;
    s_prio = p;
    s_resp = r;
    for (k = 0; k < 50 && s_ready !== 1'b1; k++) tick();
    if (k == 50) begin n_fail++; final_report(); end
    tick();
  endtask
  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 300 && phy.n_got < n; k++) tick();
    if (k == 300) begin n_fail++; final_report(); end
  endtask
  task automatic chk_log(input int i, input logic [5:0] a, input logic r, input logic [1:0] p,
                         input logic [63:0] d);
    chk(phy.pkt_log[i], {a, r, p, d});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Flow control holds staging so the queue backs up, then arbitration order
  task automatic t_order;
    chk({s_ready, phy_valid, rx_in_accept, m_valid}, 4'ha);
    partner_buf_stat = 6'h00;
    push(64'ha, 2'h0, 1'b0);
    push(64'hb, 2'h1, 1'b0);
    push(64'hc, 2'h2, 1'b0);
    push(64'hd, 2'h1, 1'b1);
    push(64'he, 2'h3, 1'b0);
    s_valid = 1'b0;
    chk(phy.n_got, 0);
    partner_buf_stat = 6'h3f;
    wait_got(5);
    chk_log(0, 6'h00, 1'b1, 2'h1, 64'hd);
    chk_log(1, 6'h01, 1'b0, 2'h2, 64'hc);
    chk_log(2, 6'h02, 1'b0, 2'h3, 64'he);
    chk_log(3, 6'h03, 1'b0, 2'h1, 64'hb);
    chk_log(4, 6'h04, 1'b0, 2'h0, 64'ha);
    phy.ack(6'h04);
  endtask
  // Retry of a response, then repeated retries of the next one with a slow PHY
  task automatic t_retry;
    phy.slow = 1'b1;
    partner_buf_stat = 6'h00;
    push(64'h11, 2'h2, 1'b1);
    push(64'h12, 2'h1, 1'b1);
    push(64'h13, 2'h0, 1'b0);
    s_valid = 1'b0;
    partner_buf_stat = 6'h3f;
    wait_got(8);
    phy.rewind(6'h05);
    wait_got(11);
    chk_log(8, 6'h05, 1'b1, 2'h3, 64'h11);
    chk_log(9, 6'h06, 1'b1, 2'h1, 64'h12);
    chk_log(10, 6'h07, 1'b0, 2'h0, 64'h13);
    for (int j = 0; j < 3; j++) begin
      phy.rewind(6'h06);
      wait_got(13 + 2 * j);
      chk_log(11 + 2 * j, 6'h06, 1'b1, (j == 0) ? 2'h2 : 2'h3, 64'h12);
      chk_log(12 + 2 * j, 6'h07, 1'b0, 2'h0, 64'h13);
    end
    phy.ack(6'h07);
    phy.slow = 1'b0;
  endtask
  // Eight slots fill, stay held while unacked, free on acknowledgement
  task automatic t_full;
    partner_buf_stat = 6'h00;
    for (int i = 0; i < 8; i++) push(64'h20 + i, 2'h0, 1'b0);
    s_valid = 1'b0;
    chk(s_ready, 1'b0);
    tx_fc_en = 1'b0;
    wait_got(25);
    chk(s_ready, 1'b0);
    phy.ack(6'h0f);
    tick();
    tick();
    chk(s_ready, 1'b1);
  endtask
  // Admission by free space with the reader stalled, then drain in order
  task automatic t_rx;
    logic [2:0] pr [13];
    logic [66:0] q [$];
    int free;
    logic e;
    pr = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h7, 3'h7};
    free = 8;
    for (int i = 0; i < 13; i++) begin
      rx_in_valid = 1'b1;
      {rx_in_resp, rx_in_prio} = pr[i];
      rx_in_data = 64'h40 + i;
      e = free >= 4 || (free == 3 && pr[i][1:0] != 2'h0) || (free == 2 && pr[i][1]) || (free == 1 && pr[i] == 3'h7);
      @(negedge ref_clk);
      chk(rx_in_accept, e);
      if (e) q.push_back({rx_in_resp, rx_in_prio, rx_in_data});
      if (e) free--;
      tick();
    end
    rx_in_valid = 1'b0;
    m_ready = 1'b1;
    foreach (q[i]) begin
      @(negedge ref_clk);
      chk({m_valid, m_resp, m_prio, m_data}, {1'b1, q[i]});
      tick();
    end
    chk(m_valid, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_order();
    t_retry();
    t_full();
    t_rx();
    final_report();
  end
endmodule // tb_retransmit_priority_buffer
